// >>> include/mbm_pkg.sv
package mbm_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned BAUD_FAST       = 19200;
  localparam int unsigned BAUD_SLOW       = 9600;
  localparam int unsigned DIV_FAST        = CLK_HZ / BAUD_FAST;
  localparam int unsigned DIV_SLOW        = CLK_HZ / BAUD_SLOW;
  localparam int unsigned TURN_MS         = 10;
  localparam int unsigned TURN_CYC        = CLK_HZ / 1000 * TURN_MS;
  localparam int unsigned GAP_BITS        = 35;
  localparam int unsigned CHAR_BITS       = 11;
  localparam int unsigned MAX_FRAME       = 256;
  localparam int unsigned MAX_SLAVES      = 8;

  // ==========================================================
  // Addresses
  localparam logic [7:0] ADDR_BCAST       = 8'h00;
  localparam logic [7:0] ADDR_SLV_MIN     = 8'h01;
  localparam logic [7:0] ADDR_SLV_MAX     = 8'h95;
  localparam logic [7:0] ADDR_VIRT_MIN    = 8'h96;
  localparam logic [7:0] ADDR_VIRT_MAX    = 8'hdc;
  localparam logic [7:0] ADDR_RSV_MIN     = 8'hf8;
  localparam logic [7:0] ADDR_RSV_MAX     = 8'hfe;
  localparam logic [7:0] ADDR_OWN_RST     = 8'hff;

  // ==========================================================
  // CRC
  localparam logic [15:0] CRC_POLY        = 16'ha001;
  localparam logic [15:0] CRC_INIT        = 16'hffff;

  // ==========================================================
  // Register map (word addressed index)
  localparam logic [3:0] REG_CTRL         = 4'h0;
  localparam logic [3:0] REG_CFG          = 4'h1;
  localparam logic [3:0] REG_STAT         = 4'h2;
  localparam logic [3:0] REG_TXDATA       = 4'h3;
  localparam logic [3:0] REG_RXDATA       = 4'h4;
  localparam logic [3:0] REG_TIMEOUT      = 4'h5;
  localparam logic [3:0] REG_OWNADDR      = 4'h6;
  localparam logic [3:0] REG_SLOTS        = 4'h7;
  localparam logic [3:0] REG_APPLIED      = 4'h8;

  // CTRL bits
  localparam int unsigned CTRL_SEND       = 0;
  localparam int unsigned CTRL_APPLY      = 1;
  localparam int unsigned CTRL_CANCEL     = 2;
  localparam int unsigned CTRL_CLRERR     = 3;
  // CFG fields
  localparam int unsigned CFG_BAUD        = 0;
  localparam int unsigned CFG_PAR_LO      = 1;
  localparam int unsigned CFG_TERM        = 3;
  localparam logic [3:0]  CFG_RST         = 4'h1;
  localparam logic [23:0] TIMEOUT_RST     = 24'h030d40;

  typedef enum logic [1:0] {
    MBM_PAR_EVEN = 2'h0,
    MBM_PAR_ODD  = 2'h1,
    MBM_PAR_NONE = 2'h2
  } mbm_par_e;

  typedef struct packed {
    logic       baud_slow;
    mbm_par_e   parity;
    logic       term;
  } mbm_cfg_s;

  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [31:0] wdata;
  } mbm_bus_s;

  typedef enum logic [5:0] {
    MBM_IDLE  = 6'b000001,
    MBM_SEND  = 6'b000010,
    MBM_GAP   = 6'b000100,
    MBM_WAIT  = 6'b001000,
    MBM_RECV  = 6'b010000,
    MBM_CHECK = 6'b100000
  } mbm_state_e;
endpackage : mbm_pkg

// >>> logic/mbm_master.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Operation
// - Only master starts a transaction
// - First byte: slave address or zero
// - Items carry sixteen-bit addresses
// - Frames never exceed 256 bytes
// - Address, function, data, then CRC16
// - Slave addresses 1 through 149
// - Addresses 248 to 254 reserved
// - Own address defaults to 255
// - At most eight slaves on line
// - Addresses 150 to 220 answered locally
// - Character is eleven bit times
// - Even default, odd or none selectable
// - No parity sends second stop bit
// - 9600 or 19200 baud, 19200 default
// - Default even parity, one stop
// - One shared rate for whole line
// - Termination on by default
// - Settings apply on reboot, cancel restores
// - TCP requests relayed, replies returned
module mbm_master (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        rx,
  output logic             tx,
  output logic             tx_en,
  output logic             term_en,
  input  wire logic        reboot
);
  // ==========================================================
  // State
  typedef struct packed {
    mbm_pkg::mbm_state_e st;
    mbm_pkg::mbm_cfg_s   live;
    mbm_pkg::mbm_cfg_s   pend;
    logic [7:0]          own;
    logic [23:0]         tmo;
    logic [7:0]          slots;
    logic [8:0]          tx_len;
    logic [8:0]          idx;
    logic [8:0]          rx_len;
    logic [10:0]         sh;
    logic [3:0]          bitn;
    logic [11:0]         bdiv;
    logic [23:0]         tcnt;
    logic [15:0]         crc;
    logic [10:0]         rsh;
    logic [3:0]          rbit;
    logic [11:0]         rdiv;
    logic                rbusy;
    logic                rx_d;
    logic                bcast;
    logic                crc_err;
    logic                tmo_err;
    logic                local_hit;
    logic                done;
    logic                ovf;
    logic [31:0]         rdata;
  } mbm_st_s;

  mbm_st_s     s_r;
  mbm_st_s     s_nxt;
  logic [7:0]  txbuf_r [0:255];
  logic [7:0]  rxbuf_r [0:255];
  logic        tx_we;
  logic [7:0]  tx_wa;
  logic        rx_we;
  logic [7:0]  rx_wa;
  logic [7:0]  rx_wd;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ mbm_pkg::CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction : crc_byte

  function automatic logic par_bit(input mbm_pkg::mbm_par_e p, input logic [7:0] b);
    return (p == mbm_pkg::MBM_PAR_ODD)  ? ~(^b) :
           (p == mbm_pkg::MBM_PAR_EVEN) ? (^b) :
           1'b1;
  endfunction : par_bit

  logic [11:0] div_now;
  logic [7:0]  dst;
  assign div_now = s_r.live.baud_slow ? 12'(mbm_pkg::DIV_SLOW) : 12'(mbm_pkg::DIV_FAST);
  assign dst = txbuf_r[0];

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] b;
    b = 8'h00;
    s_nxt = s_r;
    tx_we = 1'b0;
    tx_wa = 8'h00;
    rx_we = 1'b0;
    rx_wa = 8'h00;
    rx_wd = 8'h00;
    s_nxt.rdata = 32'h00000000;
    s_nxt.rx_d = rx;
    if (reboot) begin
      s_nxt.live = s_r.pend;
    end
    // Register writes
    if (wr) begin
      case (addr)
        mbm_pkg::REG_CTRL: begin
          if (wdata[mbm_pkg::CTRL_CANCEL]) begin
            s_nxt.pend = s_r.live;
          end
          if (wdata[mbm_pkg::CTRL_CLRERR]) begin
            // Sticky flags clear together so one status read covers one send
            s_nxt.local_hit = 1'b0;
            s_nxt.crc_err = 1'b0;
            s_nxt.tmo_err = 1'b0;
            s_nxt.ovf = 1'b0;
            s_nxt.done = 1'b0;
          end
          // Only the master starts traffic; a send while busy is ignored
          if (wdata[mbm_pkg::CTRL_SEND] && s_r.st == mbm_pkg::MBM_IDLE &&
              s_r.tx_len >= 9'd2) begin
            if (dst >= mbm_pkg::ADDR_VIRT_MIN && dst <= mbm_pkg::ADDR_VIRT_MAX ||
                dst == s_r.own) begin
              s_nxt.local_hit = 1'b1;
              s_nxt.done = 1'b1;
            end else if (dst >= mbm_pkg::ADDR_RSV_MIN && dst <= mbm_pkg::ADDR_RSV_MAX ||
                         dst > mbm_pkg::ADDR_SLV_MAX) begin
              s_nxt.ovf = 1'b1;
            end else begin
              s_nxt.local_hit = 1'b0;
              s_nxt.bcast = (dst == mbm_pkg::ADDR_BCAST);
              s_nxt.st = mbm_pkg::MBM_SEND;
              s_nxt.idx = 9'd0;
              s_nxt.bitn = 4'd0;
              s_nxt.bdiv = 12'd0;
              s_nxt.crc = mbm_pkg::CRC_INIT;
              s_nxt.rx_len = 9'd0;
              s_nxt.done = 1'b0;
            end
          end else if (wdata[mbm_pkg::CTRL_SEND]) begin
            s_nxt.ovf = s_r.ovf | (s_r.tx_len < 9'd2);
          end
          if (wdata[mbm_pkg::CTRL_APPLY] == 1'b0 && wdata[mbm_pkg::CTRL_SEND] == 1'b0 &&
              wdata[mbm_pkg::CTRL_CANCEL] == 1'b0 && wdata[mbm_pkg::CTRL_CLRERR] == 1'b0 &&
              s_r.st == mbm_pkg::MBM_IDLE) begin
            s_nxt.tx_len = 9'd0;
          end
        end
        mbm_pkg::REG_CFG: begin
          s_nxt.pend.baud_slow = wdata[mbm_pkg::CFG_BAUD];
          s_nxt.pend.parity = (wdata[mbm_pkg::CFG_PAR_LO +: 2] == 2'h3) ? mbm_pkg::MBM_PAR_EVEN :
                              mbm_pkg::mbm_par_e'(wdata[mbm_pkg::CFG_PAR_LO +: 2]);
          s_nxt.pend.term = wdata[mbm_pkg::CFG_TERM];
        end
        mbm_pkg::REG_TXDATA: begin
          // Frame buffer holds 256 bytes; the CRC is appended, so data stops at 254
          if (s_r.st == mbm_pkg::MBM_IDLE && s_r.tx_len < 9'(mbm_pkg::MAX_FRAME - 2)) begin
            tx_we = 1'b1;
            tx_wa = s_r.tx_len[7:0];
            s_nxt.tx_len = s_r.tx_len + 9'd1;
          end else begin
            s_nxt.ovf = 1'b1;
          end
        end
        mbm_pkg::REG_TIMEOUT: s_nxt.tmo = wdata[23:0];
        mbm_pkg::REG_OWNADDR: s_nxt.own = wdata[7:0];
        mbm_pkg::REG_SLOTS: s_nxt.slots = wdata[7:0];
        default: ;
      endcase
    end
    // Register reads, data one cycle later
    if (rd) begin
      case (addr)
        mbm_pkg::REG_CFG:
          s_nxt.rdata = {28'h0000000, s_r.pend.term, s_r.pend.parity, s_r.pend.baud_slow};
        mbm_pkg::REG_APPLIED:
          s_nxt.rdata = {28'h0000000, s_r.live.term, s_r.live.parity, s_r.live.baud_slow};
        mbm_pkg::REG_STAT:
          s_nxt.rdata = {7'h00, s_r.rx_len, 7'h00, s_r.tx_len[8:0]} & 32'h01ff01ff |
                        {26'h0000000, s_r.local_hit, s_r.ovf, s_r.tmo_err, s_r.crc_err,
                         s_r.done, (s_r.st != mbm_pkg::MBM_IDLE)} << 10;
        mbm_pkg::REG_RXDATA: begin
          s_nxt.rdata = {24'h000000, rxbuf_r[s_r.idx[7:0]]};
          if (s_r.st == mbm_pkg::MBM_IDLE) begin
            s_nxt.idx = s_r.idx + 9'd1;
          end
        end
        mbm_pkg::REG_TIMEOUT: s_nxt.rdata = {8'h00, s_r.tmo};
        mbm_pkg::REG_OWNADDR: s_nxt.rdata = {24'h000000, s_r.own};
        mbm_pkg::REG_SLOTS: s_nxt.rdata = {24'h000000, s_r.slots};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
    // Link engine
    case (s_r.st)
      mbm_pkg::MBM_IDLE: ;
      mbm_pkg::MBM_SEND: begin
        if (s_r.bitn == 4'd0 && s_r.bdiv == 12'd0) begin
          if (s_r.idx < s_r.tx_len) begin
            b = txbuf_r[s_r.idx[7:0]];
            s_nxt.crc = crc_byte(s_r.crc, b);
          end else if (s_r.idx == s_r.tx_len) begin
            b = s_r.crc[7:0];
          end else begin
            b = s_r.crc[15:8];
          end
          // Start, eight data, parity or second stop, stop
          s_nxt.sh = {1'b1, par_bit(s_r.live.parity, b), b, 1'b0};
        end
        if (s_r.bdiv == div_now - 12'd1) begin
          s_nxt.bdiv = 12'd0;
          s_nxt.sh = {1'b1, s_r.sh[10:1]};
          if (s_r.bitn == 4'(mbm_pkg::CHAR_BITS - 1)) begin
            s_nxt.bitn = 4'd0;
            s_nxt.idx = s_r.idx + 9'd1;
            if (s_r.idx == s_r.tx_len + 9'd1) begin
              s_nxt.st = mbm_pkg::MBM_GAP;
              s_nxt.tcnt = 24'd0;
              s_nxt.idx = 9'd0;
            end
          end else begin
            s_nxt.bitn = s_r.bitn + 4'd1;
          end
        end else begin
          s_nxt.bdiv = s_r.bdiv + 12'd1;
        end
      end
      mbm_pkg::MBM_GAP: begin
        // Inter-frame silence; broadcast ends here with no wait
        s_nxt.tcnt = s_r.tcnt + 24'd1;
        if (s_r.tcnt == 24'(mbm_pkg::GAP_BITS) * {12'h000, div_now}) begin
          s_nxt.tcnt = 24'd0;
          s_nxt.crc = mbm_pkg::CRC_INIT;
          if (s_r.bcast) begin
            s_nxt.st = mbm_pkg::MBM_IDLE;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = mbm_pkg::MBM_WAIT;
          end
        end
      end
      mbm_pkg::MBM_WAIT, mbm_pkg::MBM_RECV: begin
        s_nxt.tcnt = s_r.tcnt + 24'd1;
        if (!s_r.rbusy && s_r.rx_d && !rx) begin
          s_nxt.rbusy = 1'b1;
          s_nxt.rdiv = 12'd0;
          s_nxt.rbit = 4'd0;
          s_nxt.st = mbm_pkg::MBM_RECV;
        end
        if (s_r.rbusy) begin
          s_nxt.tcnt = 24'd0;
          s_nxt.rdiv = s_r.rdiv + 12'd1;
          if (s_r.rdiv == ((s_r.rbit == 4'd0) ? (div_now >> 1) : div_now)) begin
            s_nxt.rdiv = 12'd0;
            s_nxt.rsh = {rx, s_r.rsh[10:1]};
            s_nxt.rbit = s_r.rbit + 4'd1;
            if (s_r.rbit == 4'(mbm_pkg::CHAR_BITS - 1)) begin
              s_nxt.rbusy = 1'b0;
              // Stop bit is not stored yet; data sits just below the parity sample
              rx_wd = s_r.rsh[9:2];
              if (s_r.rx_len < 9'(mbm_pkg::MAX_FRAME)) begin
                rx_we = 1'b1;
                rx_wa = s_r.rx_len[7:0];
                s_nxt.rx_len = s_r.rx_len + 9'd1;
                s_nxt.crc = crc_byte(s_r.crc, rx_wd);
              end else begin
                s_nxt.ovf = 1'b1;
              end
            end
          end
        end else if (s_r.st == mbm_pkg::MBM_WAIT && s_r.tcnt >= s_r.tmo) begin
          s_nxt.st = mbm_pkg::MBM_IDLE;
          s_nxt.tmo_err = 1'b1;
          s_nxt.done = 1'b1;
        end else if (s_r.st == mbm_pkg::MBM_RECV &&
                     s_r.tcnt >= 24'(mbm_pkg::GAP_BITS) * {12'h000, div_now}) begin
          s_nxt.st = mbm_pkg::MBM_CHECK;
        end
      end
      mbm_pkg::MBM_CHECK: begin
        // A good CRC over the whole frame leaves a zero residue
        s_nxt.crc_err = (s_r.crc != 16'h0000) || (s_r.rx_len < 9'd4);
        s_nxt.done = 1'b1;
        s_nxt.idx = 9'd0;
        s_nxt.st = mbm_pkg::MBM_IDLE;
      end
      default: s_nxt.st = mbm_pkg::MBM_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= mbm_pkg::MBM_IDLE;
      s_r.live <= mbm_pkg::mbm_cfg_s'(mbm_pkg::CFG_RST);
      s_r.pend <= mbm_pkg::mbm_cfg_s'(mbm_pkg::CFG_RST);
      s_r.own <= mbm_pkg::ADDR_OWN_RST;
      s_r.tmo <= mbm_pkg::TIMEOUT_RST;
      s_r.slots <= 8'(mbm_pkg::MAX_SLAVES);
      s_r.sh <= 11'h7ff;
      s_r.rx_d <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && tx_we) begin
      txbuf_r[tx_wa] <= wdata[7:0];
    end
    if (ce && rx_we) begin
      rxbuf_r[rx_wa] <= rx_wd;
    end
  end

  assign rdata = s_r.rdata;
  assign tx = (s_r.st == mbm_pkg::MBM_SEND) ? s_r.sh[0] : 1'b1;
  assign tx_en = (s_r.st == mbm_pkg::MBM_SEND);
  assign term_en = s_r.live.term;

  // ==========================================================
  // Checks
  bcast_no_wait_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == mbm_pkg::MBM_GAP && s_nxt.st != mbm_pkg::MBM_GAP && s_r.bcast) |=>
    s_r.st == mbm_pkg::MBM_IDLE) else $error("broadcast waited for reply");
  tx_idle_high_a: assert property (@(posedge clock) disable iff (rst)
    !tx_en |-> tx) else $error("line driven outside send");
  own_reset_a: assert property (@(posedge clock)
    $rose(!rst) |-> s_r.own == 8'hff) else $error("own address reset wrong");
  term_reset_a: assert property (@(posedge clock)
    $fell(rst) |-> term_en && !s_r.live.baud_slow) else $error("reset config wrong");
  start_bit_a: assert property (@(posedge clock) disable iff (rst || !ce)
    ($rose(tx_en)) |-> ##1 !tx) else $error("no start bit");
  rx_len_cap_a: assert property (@(posedge clock) disable iff (rst)
    s_r.rx_len <= 9'd256 && s_r.tx_len <= 9'd254) else $error("frame too long");
  tmo_end_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == mbm_pkg::MBM_WAIT && s_nxt.st == mbm_pkg::MBM_IDLE && ce) |=> s_r.tmo_err)
    else $error("timeout not flagged");
  cfg_hold_a: assert property (@(posedge clock) disable iff (rst)
    (!reboot) |=> s_r.live == $past(s_r.live)) else $error("config changed without reboot");
  gap_line_quiet_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == mbm_pkg::MBM_GAP) |-> (tx && !tx_en))
    else $error("line driven during gap");
  send_dest_ok_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == mbm_pkg::MBM_SEND) |-> (dst <= mbm_pkg::ADDR_SLV_MAX))
    else $error("frame sent to non serial address");
  check_done_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.st == mbm_pkg::MBM_CHECK && ce) |=> (s_r.done && s_r.st == mbm_pkg::MBM_IDLE))
    else $error("check did not finish");
  bcast_c: cover property (@(posedge clock) s_r.bcast && s_r.done);
  local_c: cover property (@(posedge clock) s_r.local_hit && s_r.done);
  tmo_c: cover property (@(posedge clock) s_r.tmo_err);
  good_c: cover property (@(posedge clock) s_r.done && !s_r.crc_err && !s_r.tmo_err);
endmodule : mbm_master

// >>> verif/mbm_slave_model.sv
`timescale 1ns/10ps
// ==========================================
// Serial slave: decodes even-parity characters, echoes unicast frames
// Fixed to the master's reset line settings, as a slave that adopts them
module mbm_slave_model #(
  parameter int DIV  = 1041,
  parameter int TURN = 2000
) (
  input  wire logic clock,
  input  wire logic tx,
  input  wire logic tx_en,
  output logic      rx
);
  logic [7:0]  got[$];
  logic [10:0] ch;
  logic        en_q;
  int          n_bad;

  // Echo keeps a valid CRC without a CRC engine in the model
  task automatic send_frame();
    logic [10:0] c;
    repeat (TURN) @(posedge clock);
    foreach (got[k]) begin
      c = {1'b1, ^got[k], got[k], 1'b0};
      for (int i = 0; i < 11; i++) begin
        rx <= c[i];
        repeat (DIV) @(posedge clock);
      end
    end
    rx <= 1'b1;
  endtask : send_frame

  // Failsafe bias holds the idle line high
  initial begin
    rx    = 1'b1;
    en_q  = 1'b0;
    n_bad = 0;
    forever begin
      @(posedge clock);
      if (en_q && !tx_en && got.size() > 0 && got[0] != 8'h00) begin
        send_frame();
      end
      en_q = tx_en;
      if (tx_en && !tx) begin
        repeat (DIV / 2) @(posedge clock);
        for (int i = 0; i < 11; i++) begin
          ch[i] = tx;
          if (i < 10) repeat (DIV) @(posedge clock);
        end
        if (ch[0] || !ch[10] || ch[9] != ^ch[8:1]) n_bad++;
        got.push_back(ch[8:1]);
      end
    end
  end
endmodule : mbm_slave_model

// >>> verif/test_mbm_master.sv
`timescale 1ns/10ps
module test_mbm_master;
  // Broadcast frame dominates the run: about 82k cycles at the fast rate
  localparam int LIMIT = 99000;
  logic        clock;
  logic        rst;
  logic        ce;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        rx;
  logic        tx;
  logic        tx_en;
  logic        term_en;
  logic        reboot;
  logic [31:0] v;
  logic [7:0]  fr[$];
  logic        en_d = 1'b0;
  int          n_en = 0;
  int          n_fail;
  int          num_checks;
  logic [3:0]  ra[5] = '{4'h1, 4'h8, 4'h5, 4'h6, 4'h7};
  logic [31:0] rv[5] = '{32'h8, 32'h8, 32'h30d40, 32'hff, 32'h8};
  logic [7:0]  da[6] = '{8'h96, 8'hdc, 8'hff, 8'hf8, 8'hfe, 8'hdd};

  mbm_master dut (.clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx(rx), .tx(tx), .tx_en(tx_en), .term_en(term_en),
    .reboot(reboot));
  mbm_slave_model #(.DIV(int'(mbm_pkg::DIV_FAST)), .TURN(2000)) slave (.clock(clock),
    .tx(tx), .tx_en(tx_en), .rx(rx));

  // ==========================================
  // Clock, line activity monitor, time limit
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    en_d <= tx_en;
    if (tx_en && !en_d) n_en <= n_en + 1;
  end

  initial begin
    repeat (LIMIT) @(posedge clock);
    n_fail++;
    $display("wrong value run time expected finish seen timeout");
    final_report();
  end

  // ==========================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clock);
  endtask : rd_reg

  task automatic pulse_reboot();
    reboot <= 1'b1;
    @(posedge clock);
    reboot <= 1'b0;
    @(posedge clock);
  endtask : pulse_reboot

  task automatic send(input logic [7:0] b[$]);
    wr_reg(mbm_pkg::REG_CTRL, 32'h8);
    wr_reg(mbm_pkg::REG_CTRL, 32'h0);
    foreach (b[k]) wr_reg(mbm_pkg::REG_TXDATA, {24'h0, b[k]});
    wr_reg(mbm_pkg::REG_CTRL, 32'h1);
  endtask : send

  task automatic wait_done(input int n, output logic [31:0] st);
    for (int i = 0; i < n; i++) begin
      rd_reg(mbm_pkg::REG_STAT, st);
      if (st[11] === 1'b1) break;
    end
  endtask : wait_done

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[k]) begin
      c = c ^ {8'h00, b[k]};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ==========================================
  // Tests
  initial begin
    rst        = 1'b1;
    ce         = 1'b1;
    addr       = 4'h0;
    wdata      = 32'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    reboot     = 1'b0;
    n_fail     = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("tx idle", {31'h0, tx}, 32'h1);
    check("tx_en idle", {31'h0, tx_en}, 32'h0);
    check("term_en", {31'h0, term_en}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rd_reg(ra[i], v);
      check("reset value", v, rv[i]);
    end
    $display("test reset values done");

    for (int p = 0; p < 3; p++) begin
      wr_reg(mbm_pkg::REG_CFG, 32'h9 | (p << 1));
      rd_reg(mbm_pkg::REG_CFG, v);
      check("pending cfg", v, 32'h9 | (p << 1));
    end
    wr_reg(mbm_pkg::REG_CTRL, 32'h4);
    rd_reg(mbm_pkg::REG_CFG, v);
    check("cfg after cancel", v, 32'h8);
    wr_reg(mbm_pkg::REG_CFG, 32'h2);
    rd_reg(mbm_pkg::REG_APPLIED, v);
    check("applied before reboot", v, 32'h8);
    pulse_reboot();
    rd_reg(mbm_pkg::REG_APPLIED, v);
    check("applied after reboot", v, 32'h2);
    check("term_en off", {31'h0, term_en}, 32'h0);
    wr_reg(mbm_pkg::REG_CFG, 32'h8);
    pulse_reboot();
    rd_reg(mbm_pkg::REG_APPLIED, v);
    check("applied restored", v, 32'h8);
    $display("test line settings done");

    for (int i = 0; i < 6; i++) begin
      fr = '{da[i], 8'h03};
      send(fr);
      wait_done(20, v);
      check("local or refused", {30'h0, v[15:14]}, (i < 3) ? 32'h2 : 32'h1);
    end
    check("no line traffic", n_en, 32'h0);
    check("nothing received", slave.got.size(), 32'h0);
    $display("test local and reserved done");

    // A master that waited for a reply here would run past the poll bound
    fr = '{8'h00, 8'h08};
    send(fr);
    wait_done(50000, v);
    check("broadcast done", {31'h0, v[11]}, 32'h1);
    check("broadcast timeout flag", {31'h0, v[13]}, 32'h0);
    check("frame count", n_en, 32'h1);
    check("byte count", slave.got.size(), 32'h4);
    check("address byte", {24'h0, slave.got[0]}, 32'h0);
    check("function byte", {24'h0, slave.got[1]}, 32'h8);
    check("crc", {16'h0, slave.got[3], slave.got[2]}, {16'h0, crc16(fr)});
    check("char format", slave.n_bad, 32'h0);
    $display("test broadcast frame done");
    final_report();
  end
endmodule : test_mbm_master
